// *** logic/dpm_pkg.sv ***
// shared constants and types for the dual-port memory port controller
// Functional notes
// - controller clears its mailbox flag after power-up
// - controller stalls while its contention flag low
// - secondary role ties contention high or low
// - cascaded contention flags combined by AND
// - flag space: port select high, flag select low
package dpm_pkg;

    // ==========================================================
    // widths and addresses
    localparam int unsigned ADDR_W        = 16;
    localparam int unsigned DATA_W        = 16;
    localparam int unsigned FLAG_IDX_W    = 3;
    localparam logic [15:0] MBOX_LEFT_ADDR  = 16'hfffe;
    localparam logic [15:0] MBOX_RIGHT_ADDR = 16'hffff;

    // ==========================================================
    // timing
    localparam int unsigned SYNC_STAGES   = 2;
    localparam int unsigned T_CLK_NS      = 25;
    localparam int unsigned T_ACCESS_NS   = 20;
    localparam int unsigned T_WR_HOLD_NS  = 15;
    // least times round up to whole cycles
    localparam int unsigned ACCESS_CYC    = (T_ACCESS_NS + T_CLK_NS - 1) / T_CLK_NS;
    localparam int unsigned HOLD_CYC      = (T_WR_HOLD_NS + T_CLK_NS - 1) / T_CLK_NS;
    // strobe must also cover the input synchroniser before data is taken
    localparam int unsigned STROBE_CYC    = ACCESS_CYC + SYNC_STAGES + 1;
    localparam int unsigned CNT_W         = 4;

    // ==========================================================
    // types
    typedef enum logic [1:0] {
        DPM_OP_RD     = 2'h0,
        DPM_OP_WR     = 2'h1,
        DPM_OP_FLG_RD = 2'h2,
        DPM_OP_FLG_WR = 2'h3
    } dpm_op_t;

    typedef struct packed {
        dpm_op_t           op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } dpm_cmd_t;

    typedef struct packed {
        logic              port_select_n;
        logic              flag_space_select_n;
        logic              write_strobe_n;
        logic              output_enable_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dq_o;
        logic              dq_oe;
    } dpm_pins_t;

    localparam dpm_pins_t PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 16'h0000, 16'h0000, 1'b0};

endpackage : dpm_pkg

// *** logic/dpm_sync.sv ***
// two-flop synchroniser for a vector of asynchronous pin levels
module dpm_sync #(
    parameter int unsigned WIDTH = 1
) (
    // system
    input  wire logic             clk,
    input  wire logic             reset_n,
    // levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // first stage feeds only the second stage
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_q <= '1;
            sync_q <= '1;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule : dpm_sync

// *** logic/dpm_host.sv ***
// port controller driving one side of the dual-port memory
module dpm_host
    import dpm_pkg::*;
#(
    parameter bit          SIDE_RIGHT = 1'b0,
    parameter int unsigned N_DEV      = 1
) (
    // system
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    // user command side
    input  wire logic                  cmd_valid,
    input  wire dpm_pkg::dpm_cmd_t     cmd,
    output logic                       cmd_ready,
    output logic                       rsp_valid,
    output logic [dpm_pkg::DATA_W-1:0] rsp_data,
    output logic                       mailbox_pending,
    output logic                       init_done,
    // device pins
    output dpm_pkg::dpm_pins_t         pins,
    input  wire logic [dpm_pkg::DATA_W-1:0] dq_i,
    input  wire logic                  mailbox_flag_n,
    input  wire logic [N_DEV-1:0]      contention_flag_n
);
    import dpm_pkg::*;

    // ==========================================================
    // constants and helpers
    localparam logic [ADDR_W-1:0] OWN_MBOX  = SIDE_RIGHT ? MBOX_RIGHT_ADDR : MBOX_LEFT_ADDR;
    localparam logic [CNT_W-1:0]  STROBE_LAST = CNT_W'(STROBE_CYC - 1);
    localparam logic [CNT_W-1:0]  HOLD_LAST   = CNT_W'(HOLD_CYC - 1);

    typedef enum logic [4:0] {
        ST_IDLE    = 5'h01,
        ST_SETUP   = 5'h02,
        ST_STROBE  = 5'h04,
        ST_RECOVER = 5'h08,
        ST_WAIT    = 5'h10
    } dpm_state_t;

    // pin levels for one access, with or without its strobe
    function automatic dpm_pins_t drive(input dpm_cmd_t c, input logic strobe);
        dpm_pins_t p;
        p = PINS_IDLE;
        if (c.op == DPM_OP_FLG_RD || c.op == DPM_OP_FLG_WR) begin
            p.flag_space_select_n = 1'b0;
            p.addr = {{(ADDR_W-FLAG_IDX_W){1'b0}}, c.addr[FLAG_IDX_W-1:0]};
            p.dq_o = {{(DATA_W-1){1'b0}}, c.wdata[0]};
        end else begin
            p.port_select_n = 1'b0;
            p.addr = c.addr;
            p.dq_o = c.wdata;
        end
        if (c.op == DPM_OP_WR || c.op == DPM_OP_FLG_WR) begin
            p.dq_oe          = 1'b1;
            p.write_strobe_n = ~strobe;
        end else begin
            p.output_enable_n = ~strobe;
        end
        return p;
    endfunction : drive

    // ==========================================================
    // pin input synchronisers
    logic [DATA_W+1:0] raw_in;
    logic [DATA_W+1:0] syn_in;
    logic [DATA_W-1:0] dq_s;
    logic              mbox_n_s;
    logic              busy_n_s;

    assign raw_in = {dq_i, mailbox_flag_n, &contention_flag_n};

    dpm_sync #(
        .WIDTH   (DATA_W + 2)
    ) u_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .async_in(raw_in),
        .sync_out(syn_in)
    );

    assign dq_s     = syn_in[DATA_W+1:2];
    assign mbox_n_s = syn_in[1];
    assign busy_n_s = syn_in[0];

    // ==========================================================
    // sequencer state
    dpm_state_t        state_q, state_d;
    dpm_cmd_t          cur_q, cur_d;
    dpm_pins_t         pins_q, pins_d;
    logic [CNT_W-1:0]  cnt_q, cnt_d;
    logic              busy_seen_q, busy_seen_d;
    logic              init_q, init_d;
    logic              ready_q, ready_d;
    logic              rsp_valid_q, rsp_valid_d;
    logic [DATA_W-1:0] rsp_data_q, rsp_data_d;
    logic              mbox_q, mbox_d;

    // next-state logic for one access at a time
    always_comb begin
        state_d     = state_q;
        cur_d       = cur_q;
        pins_d      = pins_q;
        cnt_d       = cnt_q;
        busy_seen_d = busy_seen_q;
        init_d      = init_q;
        ready_d     = 1'b0;
        rsp_valid_d = 1'b0;
        rsp_data_d  = rsp_data_q;
        // mailbox level shown to the user, held by the device between events
        mbox_d      = ~mbox_n_s;
        unique case (state_q)
            ST_IDLE: begin
                if (!init_q) begin
                    cur_d   = '{DPM_OP_RD, OWN_MBOX, '0};
                    pins_d  = drive('{DPM_OP_RD, OWN_MBOX, '0}, 1'b0);
                    state_d = ST_SETUP;
                end else if (cmd_valid && ready_q) begin
                    cur_d   = cmd;
                    pins_d  = drive(cmd, 1'b0);
                    state_d = ST_SETUP;
                end else begin
                    ready_d = 1'b1;
                end
            end
            ST_SETUP: begin
                // address and select settle a cycle before the strobe
                pins_d      = drive(cur_q, 1'b1);
                cnt_d       = '0;
                busy_seen_d = 1'b0;
                state_d     = ST_STROBE;
            end
            ST_STROBE: begin
                if (!busy_n_s) begin
                    busy_seen_d = 1'b1;
                end
                if (cnt_q == STROBE_LAST) begin
                    pins_d     = drive(cur_q, 1'b0);
                    rsp_data_d = dq_s;
                    cnt_d      = '0;
                    state_d    = ST_RECOVER;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            ST_RECOVER: begin
                // data and address held past the strobe edge
                if (!busy_n_s) begin
                    busy_seen_d = 1'b1;
                end
                if (cnt_q == HOLD_LAST) begin
                    // select released, so a flag latch read can refresh next time
                    pins_d = PINS_IDLE;
                    if (busy_seen_q || !busy_n_s) begin
                        state_d = ST_WAIT;
                    end else begin
                        state_d = ST_IDLE;
                        if (init_q) begin
                            rsp_valid_d = 1'b1;
                        end
                        init_d = 1'b1;
                    end
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            ST_WAIT: begin
                // stall until contention clears, then retry whole access
                if (busy_n_s) begin
                    pins_d  = drive(cur_q, 1'b0);
                    state_d = ST_SETUP;
                end
            end
        endcase
    end

    // registers only
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q     <= ST_IDLE;
            cur_q       <= '0;
            pins_q      <= PINS_IDLE;
            cnt_q       <= '0;
            busy_seen_q <= 1'b0;
            init_q      <= 1'b0;
            ready_q     <= 1'b0;
            rsp_valid_q <= 1'b0;
            rsp_data_q  <= '0;
            mbox_q      <= 1'b0;
        end else begin
            state_q     <= state_d;
            cur_q       <= cur_d;
            pins_q      <= pins_d;
            cnt_q       <= cnt_d;
            busy_seen_q <= busy_seen_d;
            init_q      <= init_d;
            ready_q     <= ready_d;
            rsp_valid_q <= rsp_valid_d;
            rsp_data_q  <= rsp_data_d;
            mbox_q      <= mbox_d;
        end
    end

    // ==========================================================
    // outputs straight from flops
    assign pins            = pins_q;
    assign cmd_ready       = ready_q;
    assign rsp_valid       = rsp_valid_q;
    assign rsp_data        = rsp_data_q;
    assign mailbox_pending = mbox_q;
    assign init_done       = init_q;

endmodule : dpm_host

// *** test/dpm_host_props.sv ***
// checker on the port controller pins and user handshake
module dpm_host_props
    import dpm_pkg::*;
#(
    parameter int unsigned N_DEV = 1
) (
    // system
    input wire logic               clk,
    input wire logic               reset_n,
    // user side and pins
    input wire logic               cmd_valid,
    input wire logic               cmd_ready,
    input wire logic               rsp_valid,
    input wire logic               init_done,
    input wire dpm_pkg::dpm_pins_t pins,
    input wire logic [N_DEV-1:0]   contention_flag_n
);
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================================
    // sequences
    default clocking @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    sequence s_take;
        cmd_valid && cmd_ready;
    endsequence
    sequence s_busy5;
        !(&contention_flag_n) [*5];
    endsequence
    sequence s_quiet7;
        !rsp_valid [*7];
    endsequence
    // ==========================================================
    // assertions
    space_select_a: assert property (!pins.flag_space_select_n |-> pins.port_select_n)
        else $error("flag space reached with memory select low");
    strobe_select_a: assert property (!pins.write_strobe_n || !pins.output_enable_n |->
        !pins.port_select_n || !pins.flag_space_select_n) else $error("strobe without a select");
    write_data_a: assert property (!pins.write_strobe_n |-> pins.dq_oe && pins.output_enable_n)
        else $error("write strobe without driven data");
    addr_setup_a: assert property ($fell(pins.write_strobe_n) |-> $stable(pins.addr))
        else $error("address moved as the write began");
    stall_wait_a: assert property (s_busy5 |-> pins.write_strobe_n && pins.output_enable_n)
        else $error("strobing while contention is low");
    init_gate_a: assert property (!init_done |-> !cmd_ready)
        else $error("request accepted before mailbox clear");
    take_once_a: assert property (s_take |=> !cmd_ready)
        else $error("ready stayed high after a take");
    rsp_gap_a: assert property (s_take |-> s_quiet7)
        else $error("response sooner than a full access");
endmodule : dpm_host_props

bind dpm_host dpm_host_props #(.N_DEV(N_DEV)) u_props (.clk(clk), .reset_n(reset_n), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .init_done(init_done), .pins(pins),
    .contention_flag_n(contention_flag_n));

// *** test/dpm_dev_model.sv ***
// behavioural memory device as seen from its left port
module dpm_dev_model
    import dpm_pkg::*;
(
    // left port pins and far side controls
    input  wire dpm_pkg::dpm_pins_t    pins,
    input  wire logic                  contention_n,
    input  wire logic                  remote_set,
    input  wire logic                  remote_read,
    input  wire logic [7:0]            remote_owns,
    // answers
    output logic [dpm_pkg::DATA_W-1:0] dq,
    output logic                       own_mbox_n,
    output logic                       far_mbox_n
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] mem [logic [15:0]];
    logic [7:0]  sem_q;
    logic [15:0] last_q;
    // flags only move on their own events
    // own flag starts asserted so a missing clear shows up
    initial begin
        own_mbox_n = 1'b0;
        far_mbox_n = 1'b1;
        sem_q = 8'hff;
        last_q = 16'h0000;
    end
    // released bus shows the inverse of the last driven value, not a stale copy
    // flag replicated on every data bit
    always @(pins, sem_q) begin
        if (!pins.output_enable_n && !pins.port_select_n) begin
            dq = mem.exists(pins.addr) ? mem[pins.addr] : 16'h0000;
            last_q = dq;
        end else if (!pins.output_enable_n && !pins.flag_space_select_n) begin
            dq = {16{sem_q[pins.addr[2:0]]}};
            last_q = dq;
        end else begin
            dq = ~last_q;
        end
    end
    always @(posedge pins.write_strobe_n) begin
        if (contention_n && !pins.port_select_n) begin
            mem[pins.addr] = pins.dq_o;
            if (pins.addr == MBOX_RIGHT_ADDR)
                far_mbox_n = 1'b0;
        end
        if (!pins.flag_space_select_n)
            sem_q[pins.addr[2:0]] = pins.dq_o[0] | remote_owns[pins.addr[2:0]];
    end
    // enabled access of the left word clears own flag
    always @(negedge pins.output_enable_n) begin
        if (!pins.port_select_n && pins.addr == MBOX_LEFT_ADDR && contention_n)
            own_mbox_n = 1'b1;
    end
    // far side writes the left mailbox word
    always @(posedge remote_set) begin
        own_mbox_n = 1'b0;
    end
    // far side reads its word and clears its flag
    always @(posedge remote_read) begin
        far_mbox_n = 1'b1;
    end
endmodule : dpm_dev_model

// *** test/tb_dpm_host.sv ***
// self-checking bench for the port controller against the device model
module tb_dpm_host;
    timeunit 1ns;
    timeprecision 100ps;
    import dpm_pkg::*;
    logic        clk, reset_n, cmd_valid, busy_n, remote_set, cmd_ready, rsp_valid, pend, init_done;
    logic        own_n, far_n, remote_read;
    logic [7:0]  owns;
    logic [15:0] rsp_data, dq_i, rdata;
    dpm_cmd_t    cmd;
    dpm_pins_t   pins;
    int          fail_count = 0;
    int          total_checks = 0;
    dpm_host #(.SIDE_RIGHT(1'b0), .N_DEV(1)) dut (.clk(clk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd(cmd),
        .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .mailbox_pending(pend),
        .init_done(init_done), .pins(pins), .dq_i(dq_i), .mailbox_flag_n(own_n), .contention_flag_n(busy_n));
    dpm_dev_model dev (.pins(pins), .contention_n(busy_n), .remote_set(remote_set), .remote_read(remote_read),
        .remote_owns(owns), .dq(dq_i), .own_mbox_n(own_n), .far_mbox_n(far_n));
    // ==========================================================
    // helpers
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // request held until taken, answer read where it stands
    task automatic op(dpm_op_t kind, logic [15:0] a, logic [15:0] d);
        int n;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd <= '{kind, a, d};
        n = 0;
        do @(negedge clk); while (cmd_ready !== 1'b1 && ++n < 100);
        @(posedge clk);
        cmd_valid <= 1'b0;
        n = 0;
        do @(negedge clk); while (rsp_valid !== 1'b1 && ++n < 200);
        check("response", {15'h0000, rsp_valid}, 16'h0001);
        rdata = rsp_data;
    endtask : op
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up
    // ==========================================================
    // clock and watchdog, generous against some 120 cycles of tests
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        #200us;
        fail_count++;
        wrap_up();
    end
    // ==========================================================
    // tests
    initial begin
        reset_n = 1'b0;
        cmd_valid = 1'b0;
        cmd = '0;
        busy_n = 1'b1;
        remote_set = 1'b0;
        remote_read = 1'b0;
        owns = 8'h20;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        repeat (50) if (init_done !== 1'b1) @(negedge clk);
        check("init_done", {15'h0000, init_done}, 16'h0001);
        check("own flag", {15'h0000, own_n}, 16'h0001);
        $display("power-up test done");
        @(posedge clk);
        remote_set <= 1'b1;
        @(posedge clk);
        remote_set <= 1'b0;
        repeat (20) if (pend !== 1'b1) @(negedge clk);
        check("pending set", {15'h0000, pend}, 16'h0001);
        op(DPM_OP_WR, 16'hfffe, 16'h1234);
        check("own flag after write", {15'h0000, own_n}, 16'h0000);
        op(DPM_OP_RD, 16'hfffe, 16'h0000);
        check("mailbox word", rdata, 16'h1234);
        check("far flag idle", {15'h0000, far_n}, 16'h0001);
        repeat (20) if (pend !== 1'b0) @(negedge clk);
        check("pending clear", {15'h0000, pend}, 16'h0000);
        $display("mailbox test done");
        fork
            op(DPM_OP_WR, 16'hffff, 16'ha5c3);
            begin
                repeat (4) @(posedge clk);
                busy_n <= 1'b0;
                repeat (20) @(posedge clk);
                check("far flag held", {15'h0000, far_n}, 16'h0001);
                busy_n <= 1'b1;
            end
        join
        check("far flag set", {15'h0000, far_n}, 16'h0000);
        op(DPM_OP_RD, 16'hffff, 16'h0000);
        check("retried word", rdata, 16'ha5c3);
        check("far flag kept", {15'h0000, far_n}, 16'h0000);
        @(posedge clk);
        remote_read <= 1'b1;
        @(posedge clk);
        remote_read <= 1'b0;
        check("far flag cleared", {15'h0000, far_n}, 16'h0001);
        $display("contention test done");
        op(DPM_OP_FLG_WR, 16'h0003, 16'h0000);
        op(DPM_OP_FLG_RD, 16'h0003, 16'h0000);
        check("flag taken", rdata, 16'h0000);
        op(DPM_OP_FLG_WR, 16'h0005, 16'h0000);
        op(DPM_OP_FLG_RD, 16'h0005, 16'h0000);
        check("flag refused", rdata, 16'hffff);
        op(DPM_OP_FLG_WR, 16'h0003, 16'h0001);
        op(DPM_OP_FLG_RD, 16'h0003, 16'h0000);
        check("flag freed", rdata, 16'hffff);
        $display("flag space test done");
        wrap_up();
    end
endmodule : tb_dpm_host
